/* File: rtl/erc_error_log.sv */
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module erc_error_log #(
    parameter int unsigned WIN_CYCLES = `ERC_WIN_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    input  wire logic        rc_addr_data_mismatch,
    input  wire logic        rc_bus_lines_a_mismatch,
    input  wire logic        rc_bus_drive_out_mismatch,
    input  wire logic        rc_module_check_mismatch,
    input  wire logic        bus_parity_err,
    input  wire logic        bus_fault_report_lines_err,
    input  wire logic        local_fault_report_lines_err,
    input  wire logic        status_change_in,
    input  wire logic        mem_err_flag,
    input  wire logic        uncorrectable_flag,
    input  wire logic        correction_output,
    input  wire logic        ext_err,
    input  wire logic        peer_report_valid,
    input  wire logic [4:0]  peer_report_type,
    input  wire logic [7:0]  peer_report_loc,
    output logic             report_out_valid,
    output logic      [4:0]  report_out_type,
    output logic      [7:0]  report_out_loc,
    output logic      [4:0]  recovery_type,
    output logic      [7:0]  recovery_loc,
    output logic             status_change_out
);

    erc_pkg::erc_state_t s_r;
    erc_pkg::erc_state_t s_nxt;

    logic       com_fall;
    logic [4:0] det_type;
    logic       det_bus;
    logic [7:0] det_loc;
    logic       cmd_v;
    logic [4:0] cmd_type;
    logic [7:0] cmd_loc;
    logic [4:0] peer_type;
    logic [4:0] w_type;
    logic [7:0] w_loc;
    logic       w_own;
    logic       w_v;
    logic       same_rep;

    // location from module or bus identifier
    function automatic logic [7:0] loc_pick(
        input logic       use_bus,
        input logic       bsd,
        input logic [7:0] mod_id,
        input logic [7:0] bus_id
    );
        loc_pick = (bsd || !use_bus) ? mod_id : bus_id;
    endfunction

    // ************************************************************
    // detection and selection
    // ************************************************************
    assign com_fall = s_r.com_rep && s_r.com_d && !status_change_in;

    erc_classify u_classify (
        .rc_addr_data_mismatch        (rc_addr_data_mismatch),
        .rc_bus_lines_a_mismatch      (rc_bus_lines_a_mismatch),
        .rc_bus_drive_out_mismatch    (rc_bus_drive_out_mismatch),
        .rc_module_check_mismatch     (rc_module_check_mismatch),
        .bus_parity_err               (bus_parity_err),
        .bus_fault_report_lines_err   (bus_fault_report_lines_err),
        .local_fault_report_lines_err (local_fault_report_lines_err),
        .com_fall                     (com_fall),
        .mem_err_flag                 (mem_err_flag),
        .uncorrectable_flag           (uncorrectable_flag),
        .correction_output            (correction_output),
        .ext_err                      (ext_err),
        .cur_type                     (s_r.cur_type),
        .cur_loc                      (s_r.cur_loc),
        .mod_id                       (s_r.mod_id),
        .bus_id                       (s_r.bus_id),
        .det_type                     (det_type),
        .det_bus                      (det_bus)
    );

    assign det_loc = loc_pick(det_bus, s_r.bsd, s_r.mod_id, s_r.bus_id);

    // commands only count while software has permitted them
    assign cmd_v    = wr && (addr == `ERC_A_CMD) && s_r.permit
                      && (wdata[4:0] != `ERC_T_NOP);
    assign cmd_type = cmd_v ? wdata[4:0] : `ERC_T_NOP;
    assign cmd_loc  = loc_pick((cmd_type == `ERC_T_ATT) || (cmd_type == `ERC_T_DET),
                               s_r.bsd, s_r.mod_id, s_r.bus_id);
    assign peer_type = peer_report_valid ? peer_report_type : `ERC_T_NOP;

    erc_select u_select (
        .a_type (det_type),
        .a_loc  (det_loc),
        .b_type (cmd_type),
        .b_loc  (cmd_loc),
        .c_type (peer_type),
        .c_loc  (peer_report_loc),
        .w_type (w_type),
        .w_loc  (w_loc),
        .w_own  (w_own)
    );

    assign w_v      = (w_type != `ERC_T_NOP);
    assign same_rep = (w_type == s_r.cur_type) && (w_loc == s_r.cur_loc);

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_nxt          = s_r;
        s_nxt.rdata    = 32'h0000_0000;
        s_nxt.rep_v    = 1'b0;
        s_nxt.com_d    = status_change_in;

        if (wr) begin
            unique case (addr)
                `ERC_A_CTRL: begin
                    s_nxt.permit  = wdata[`ERC_CTRL_PERMIT];
                    s_nxt.bsd     = wdata[`ERC_CTRL_BSD];
                    s_nxt.com_rep = wdata[`ERC_CTRL_COMREP];
                end
                `ERC_A_STCHG: begin
                    s_nxt.stchg = wdata[7:0];
                end
                `ERC_A_IDS: begin
                    s_nxt.mod_id = wdata[7:0];
                    s_nxt.bus_id = wdata[15:8];
                end
                `ERC_A_STAT: begin
                    if (wdata[`ERC_STAT_PERM]) begin
                        s_nxt.perm = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (cmd_v) begin
            s_nxt.permit = 1'b0;
        end

        if (rd) begin
            unique case (addr)
                `ERC_A_CTRL:  s_nxt.rdata = {29'h0000_0000, s_r.com_rep, s_r.bsd, s_r.permit};
                `ERC_A_STCHG: s_nxt.rdata = {24'h00_0000, s_r.stchg};
                `ERC_A_LOG:   s_nxt.rdata = {16'h0000, s_r.cur_loc, 3'h0, s_r.cur_type};
                `ERC_A_REC:   s_nxt.rdata = {16'h0000, s_r.prev_loc, 3'h0, s_r.prev_type};
                `ERC_A_IDS:   s_nxt.rdata = {16'h0000, s_r.bus_id, s_r.mod_id};
                `ERC_A_STAT:  s_nxt.rdata = {30'h0000_0000,
                                             s_r.win == erc_pkg::ERC_W_OPEN, s_r.perm};
                default:      s_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // window countdown; a new report below restarts it, except an ERC_T_TPEW report, which closes it
        if (s_r.win == erc_pkg::ERC_W_OPEN) begin
            if (s_r.win_cnt == 32'h0000_0000) begin
                s_nxt.win = erc_pkg::ERC_W_IDLE;
            end else begin
                s_nxt.win_cnt = s_r.win_cnt - 32'h0000_0001;
            end
        end

        // only the winner is logged; losers are dropped
        if (w_v) begin
            s_nxt.prev_type = s_r.cur_type;
            s_nxt.prev_loc  = s_r.cur_loc;
            s_nxt.cur_type  = w_type;
            s_nxt.cur_loc   = w_loc;
            if (w_own) begin
                s_nxt.rep_v    = 1'b1;
                s_nxt.rep_type = w_type;
                s_nxt.rep_loc  = w_loc;
            end
            // set placed after the software clear so it wins
            if ((w_type == `ERC_T_UNSAFE) || (w_type == `ERC_T_PRIM)) begin
                s_nxt.perm = 1'b1;
            end
            if ((s_r.win == erc_pkg::ERC_W_OPEN) && same_rep
                && (w_type != `ERC_T_TPEW)) begin
                s_nxt.perm = 1'b1;
            end
            if (w_type == `ERC_T_TPEW) begin
                s_nxt.win = erc_pkg::ERC_W_IDLE;
            end else begin
                s_nxt.win     = erc_pkg::ERC_W_OPEN;
                s_nxt.win_cnt = 32'(WIN_CYCLES - 1);
            end
        end

        if (!rst_n) begin
            s_nxt        = '0;
            s_nxt.win    = erc_pkg::ERC_W_IDLE;
            s_nxt.mod_id = `ERC_RST_ID;
            s_nxt.bus_id = `ERC_RST_ID;
        end
    end

    always_ff @(posedge clock) begin
        s_r <= s_nxt;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign rdata             = s_r.rdata;
    assign report_out_valid  = s_r.rep_v;
    assign report_out_type   = s_r.rep_type;
    assign report_out_loc    = s_r.rep_loc;
    assign recovery_type     = s_r.cur_type;
    assign recovery_loc      = s_r.cur_loc;
    assign status_change_out = s_r.perm;

    // ************************************************************
    // assertions
    // ************************************************************
    logic [12:0] det_vec;
    assign det_vec = {rc_addr_data_mismatch, rc_bus_lines_a_mismatch,
                      rc_bus_drive_out_mismatch, rc_module_check_mismatch,
                      bus_parity_err, bus_fault_report_lines_err,
                      local_fault_report_lines_err, com_fall, mem_err_flag,
                      uncorrectable_flag, ext_err, peer_report_valid, cmd_v};

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_reset_zero;
        @(posedge clock) $rose(rst_n) |-> (recovery_type == `ERC_T_NOP) && !status_change_out;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("log not zero after reset");

    property p_peer_wins;
        peer_report_valid && (peer_report_type > det_type) && !cmd_v
        |=> recovery_type == $past(peer_report_type);
    endproperty
    a_peer_wins: assert property (p_peer_wins)
        else $error("higher peer report not recorded");

    property p_local_kept;
        peer_report_valid && (peer_report_type < det_type) && !cmd_v
        |=> (recovery_type == $past(det_type)) && report_out_valid;
    endproperty
    a_local_kept: assert property (p_local_kept)
        else $error("lower peer report displaced local one");

    property p_permit_clear;
        cmd_v |=> !s_r.permit ##1 (s_r.permit == $past(wr && addr == `ERC_A_CTRL && wdata[0]));
    endproperty
    a_permit_clear: assert property (p_permit_clear)
        else $error("permit not cleared by command");

    property p_arb_only;
        rc_bus_drive_out_mismatch && ($countones(det_vec) == 1)
        |=> (recovery_type == `ERC_T_ARB)
            && (recovery_loc == ($past(s_r.bsd) ? $past(s_r.mod_id) : $past(s_r.bus_id)));
    endproperty
    a_arb_only: assert property (p_arb_only)
        else $error("drive-out mismatch misclassified");

    property p_unsafe;
        ext_err || rc_module_check_mismatch
        |=> (recovery_type == `ERC_T_UNSAFE) && status_change_out;
    endproperty
    a_unsafe: assert property (p_unsafe)
        else $error("external error not unsafe and permanent");

    property p_uncorr;
        mem_err_flag && uncorrectable_flag && ($countones(det_vec) == 2)
        |=> recovery_type == `ERC_T_UNC;
    endproperty
    a_uncorr: assert property (p_uncorr)
        else $error("uncorrectable memory error misclassified");

    property p_escalate;
        local_fault_report_lines_err && (recovery_type == `ERC_T_ERE)
        && (recovery_loc == s_r.mod_id) |=> recovery_type == `ERC_T_UNSAFE;
    endproperty
    a_escalate: assert property (p_escalate)
        else $error("repeated report-line fault not escalated");

    property p_shift;
        w_v |=> (s_r.prev_type == $past(recovery_type))
                && (s_r.prev_loc == $past(recovery_loc));
    endproperty
    a_shift: assert property (p_shift)
        else $error("previous log not loaded from current");

    property p_permanent;
        w_v && same_rep && (s_r.win == erc_pkg::ERC_W_OPEN) && (w_type != `ERC_T_TPEW)
        |=> status_change_out ##1 (status_change_out
            || $past(wr && (addr == `ERC_A_STAT) && wdata[`ERC_STAT_PERM]));
    endproperty
    a_permanent: assert property (p_permanent)
        else $error("repeated report not flagged permanent");

    property p_bsd_loc;
        w_v && w_own && s_r.bsd |=> report_out_loc == $past(s_r.mod_id);
    endproperty
    a_bsd_loc: assert property (p_bsd_loc)
        else $error("bus-switch-disable location wrong");

    c_peer_report: cover property (peer_report_valid ##1 recovery_type != `ERC_T_NOP);
    c_command:     cover property (cmd_v ##1 report_out_valid);
    c_permanent:   cover property ($rose(status_change_out));
    c_coincide:    cover property (peer_report_valid && det_type != `ERC_T_NOP);

endmodule
`default_nettype wire

/* File: rtl/erc_regs.svh */
`ifndef ERC_REGS_SVH
`define ERC_REGS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define ERC_A_CTRL      8'h00
`define ERC_A_STCHG     8'h04
`define ERC_A_LOG       8'h08
`define ERC_A_REC       8'h0C
`define ERC_A_IDS       8'h10
`define ERC_A_CMD       8'h14
`define ERC_A_STAT      8'h18

// ************************************************************
// field positions
// ************************************************************
`define ERC_CTRL_PERMIT 0
`define ERC_CTRL_BSD    1
`define ERC_CTRL_COMREP 2
`define ERC_STAT_PERM   0
`define ERC_STAT_WIN    1

// ************************************************************
// error type codes, code equals priority number
// ************************************************************
`define ERC_T_NOP       5'h00
`define ERC_T_UNSAFE    5'h1F
`define ERC_T_PRIM      5'h1E
`define ERC_T_SHAD      5'h1D
`define ERC_T_ERE       5'h1C
`define ERC_T_ARB       5'h1B
`define ERC_T_PAR       5'h1A
`define ERC_T_COMP      5'h19
`define ERC_T_UNC       5'h17
`define ERC_T_CECC      5'h16
`define ERC_T_COMALT    5'h15
`define ERC_T_ATT       5'h13
`define ERC_T_DET       5'h12
`define ERC_T_TPEW      5'h11
`define ERC_T_SYNC      5'h10

// ************************************************************
// reset values and timing
// ************************************************************
`define ERC_RST_ID      8'h00
`define ERC_WIN_CYCLES  32'h0000_1000

`endif

/* File: rtl/erc_pkg.sv */
package erc_pkg;

    typedef enum logic [1:0] {
        ERC_W_IDLE = 2'b01,
        ERC_W_OPEN = 2'b10
    } erc_win_t;

    typedef struct packed {
        logic [4:0]  cur_type;
        logic [7:0]  cur_loc;
        logic [4:0]  prev_type;
        logic [7:0]  prev_loc;
        logic        permit;
        logic        bsd;
        logic        com_rep;
        logic        perm;
        logic        com_d;
        logic [7:0]  stchg;
        logic [7:0]  mod_id;
        logic [7:0]  bus_id;
        erc_win_t    win;
        logic [31:0] win_cnt;
        logic [31:0] rdata;
        logic        rep_v;
        logic [4:0]  rep_type;
        logic [7:0]  rep_loc;
    } erc_state_t;

endpackage

/* File: rtl/erc_classify.sv */
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module erc_classify (
    input  wire logic       rc_addr_data_mismatch,
    input  wire logic       rc_bus_lines_a_mismatch,
    input  wire logic       rc_bus_drive_out_mismatch,
    input  wire logic       rc_module_check_mismatch,
    input  wire logic       bus_parity_err,
    input  wire logic       bus_fault_report_lines_err,
    input  wire logic       local_fault_report_lines_err,
    input  wire logic       com_fall,
    input  wire logic       mem_err_flag,
    input  wire logic       uncorrectable_flag,
    input  wire logic       correction_output,
    input  wire logic       ext_err,
    input  wire logic [4:0] cur_type,
    input  wire logic [7:0] cur_loc,
    input  wire logic [7:0] mod_id,
    input  wire logic [7:0] bus_id,
    output logic      [4:0] det_type,
    output logic            det_bus
);

    logic bus_ere_here;
    logic loc_ere_here;

    assign bus_ere_here = (cur_type == `ERC_T_ERE) && (cur_loc == bus_id);
    assign loc_ere_here = (cur_type == `ERC_T_ERE) && (cur_loc == mod_id);

    // later assignments override earlier ones: ascending priority
    always_comb begin
        det_type = `ERC_T_NOP;
        det_bus  = 1'b0;
        if (com_fall) begin
            det_type = `ERC_T_COMALT;
        end
        if (mem_err_flag && !uncorrectable_flag && !correction_output) begin
            det_type = `ERC_T_CECC;
        end
        if (mem_err_flag && uncorrectable_flag) begin
            det_type = `ERC_T_UNC;
        end
        if (rc_addr_data_mismatch || rc_bus_lines_a_mismatch) begin
            det_type = `ERC_T_COMP;
            det_bus  = 1'b0;
        end
        if (bus_parity_err) begin
            det_type = `ERC_T_PAR;
            det_bus  = 1'b1;
        end
        if (rc_bus_drive_out_mismatch) begin
            det_type = `ERC_T_ARB;
            det_bus  = 1'b1;
        end
        if (bus_fault_report_lines_err) begin
            det_type = `ERC_T_ERE;
            det_bus  = 1'b1;
        end
        // both pairs faulty: module identifier wins, unless the bus pair repeats an ERC_T_ERE logged at the bus identifier
        if (local_fault_report_lines_err) begin
            det_type = `ERC_T_ERE;
            det_bus  = 1'b0;
        end
        if (bus_fault_report_lines_err && bus_ere_here) begin
            det_type = `ERC_T_UNSAFE;
            det_bus  = 1'b1;
        end
        if (local_fault_report_lines_err && loc_ere_here) begin
            det_type = `ERC_T_UNSAFE;
            det_bus  = 1'b0;
        end
        if (rc_module_check_mismatch || ext_err) begin
            det_type = `ERC_T_UNSAFE;
            det_bus  = 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: rtl/erc_select.sv */
`timescale 1ns/1ps
`default_nettype none

module erc_select (
    input  wire logic [4:0] a_type,
    input  wire logic [7:0] a_loc,
    input  wire logic [4:0] b_type,
    input  wire logic [7:0] b_loc,
    input  wire logic [4:0] c_type,
    input  wire logic [7:0] c_loc,
    output logic      [4:0] w_type,
    output logic      [7:0] w_loc,
    output logic            w_own
);

    // ties go to the earlier input; type zero never wins
    always_comb begin
        w_type = a_type;
        w_loc  = a_loc;
        w_own  = 1'b1;
        if (b_type > w_type) begin
            w_type = b_type;
            w_loc  = b_loc;
        end
        if (c_type > w_type) begin
            w_type = c_type;
            w_loc  = c_loc;
            w_own  = 1'b0;
        end
    end

endmodule
`default_nettype wire

/* File: test/erc_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// peer unit on the report lines
// ************************************************************
module erc_peer_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       go,
    input  wire logic [4:0] go_type,
    input  wire logic [7:0] go_loc,
    output logic            peer_report_valid,
    output logic      [4:0] peer_report_type,
    output logic      [7:0] peer_report_loc
);
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            peer_report_valid <= 1'b0;
            peer_report_type  <= 5'h00;
            peer_report_loc   <= 8'h00;
        end else begin
            peer_report_valid <= go;
            // idle fields flip, so a stale copy never looks like a report
            peer_report_type  <= go ? go_type : ~peer_report_type;
            peer_report_loc   <= go ? go_loc : ~peer_report_loc;
        end
    end
endmodule

`default_nettype wire

/* File: test/error_report_classify_log_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "erc_regs.svh"

module error_report_classify_log_test;
    typedef struct packed {
        logic [10:0] det;
        logic [4:0]  t;
        logic [7:0]  l;
    } erc_row_t;

    logic        clock, rst_n, wr, rd, sc_in, go, pv, scout, rov;
    logic [7:0]  addr, go_loc, ploc, rloc, rol;
    logic [31:0] wdata, rdata;
    logic [10:0] det;
    logic [4:0]  go_type, ptype, rtype, rot;
    int          n_fail, checked;
    // det: ad, lines_a, drive_out, module_check, parity, bus lines, local lines,
    // mem, uncorrectable, correction, ext
    erc_row_t rows [14] = '{
        '{11'h400, 5'h19, 8'h5A}, '{11'h200, 5'h19, 8'h5A}, '{11'h100, 5'h1B, 8'hA5},
        '{11'h040, 5'h1A, 8'hA5}, '{11'h020, 5'h1C, 8'hA5}, '{11'h020, 5'h1F, 8'hA5},
        '{11'h010, 5'h1C, 8'h5A}, '{11'h010, 5'h1F, 8'h5A}, '{11'h008, 5'h16, 8'h5A},
        '{11'h00C, 5'h17, 8'h5A}, '{11'h00A, 5'h17, 8'h5A}, '{11'h080, 5'h1F, 8'h5A},
        '{11'h001, 5'h1F, 8'h5A}, '{11'h540, 5'h1B, 8'hA5}};

    erc_error_log #(.WIN_CYCLES(8)) i_dut (
        .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .rc_addr_data_mismatch(det[10]), .rc_bus_lines_a_mismatch(det[9]),
        .rc_bus_drive_out_mismatch(det[8]), .rc_module_check_mismatch(det[7]),
        .bus_parity_err(det[6]), .bus_fault_report_lines_err(det[5]),
        .local_fault_report_lines_err(det[4]), .status_change_in(sc_in),
        .mem_err_flag(det[3]), .uncorrectable_flag(det[2]), .correction_output(det[1]),
        .ext_err(det[0]), .peer_report_valid(pv), .peer_report_type(ptype),
        .peer_report_loc(ploc), .report_out_valid(rov), .report_out_type(rot),
        .report_out_loc(rol), .recovery_type(rtype), .recovery_loc(rloc),
        .status_change_out(scout));

    erc_peer_model i_peer (
        .clock(clock), .rst_n(rst_n), .go(go), .go_type(go_type), .go_loc(go_loc),
        .peer_report_valid(pv), .peer_report_type(ptype), .peer_report_loc(ploc));

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rec(input logic [4:0] t, input logic [7:0] l);
        chk("recovery_type", 32'(rtype), 32'(t));
        chk("recovery_loc", 32'(rloc), 32'(l));
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk("rdata", rdata, exp);
    endtask

    task automatic pulse(input logic [10:0] v);
        @(posedge clock);
        det <= v;
        @(posedge clock);
        det <= 11'h000;
        #1;
    endtask

    // peer report lands in the same cycle as the local event v
    task automatic peer(input logic [4:0] t, input logic [7:0] l, input logic [10:0] v);
        @(posedge clock);
        go <= 1'b1;
        go_type <= t;
        go_loc <= l;
        @(posedge clock);
        go <= 1'b0;
        det <= v;
        @(posedge clock);
        det <= 11'h000;
        #1;
    endtask

    task automatic test_done();
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ************************************************************
    // stimulus
    // ************************************************************
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        repeat (5000) @(posedge clock);
        n_fail++;
        test_done();
    end

    initial begin
        {rst_n, wr, rd, sc_in, go, addr, wdata, det, go_type, go_loc} = '0;
        n_fail = 0;
        checked = 0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        wr_reg(`ERC_A_IDS, 32'h0000_A55A);
        for (int i = 0; i < 14; i++) begin
            pulse(rows[i].det);
            rec(rows[i].t, rows[i].l);
            chk("report_out_type", 32'(rot), 32'(rows[i].t));
            chk("report_out_loc", 32'(rol), 32'(rows[i].l));
        end
        rd_reg(`ERC_A_LOG, 32'h0000_A51B);
        rd_reg(`ERC_A_REC, 32'h0000_5A1F);
        chk("status_change_out", 32'(scout), 32'h1);
        wr_reg(`ERC_A_STAT, 32'h1);
        pulse(11'h040);
        chk("status_change_out", 32'(scout), 32'h0);
        pulse(11'h040);
        chk("status_change_out", 32'(scout), 32'h1);
        wr_reg(`ERC_A_STAT, 32'h1);
        repeat (20) @(posedge clock);
        pulse(11'h040);
        chk("status_change_out", 32'(scout), 32'h0);
        wr_reg(`ERC_A_CMD, 32'h10);
        rd_reg(`ERC_A_LOG, 32'h0000_A51A);
        wr_reg(`ERC_A_STCHG, 32'h1);
        wr_reg(`ERC_A_CTRL, 32'h1);
        wr_reg(`ERC_A_CMD, 32'h10);
        rd_reg(`ERC_A_LOG, 32'h0000_5A10);
        rd_reg(`ERC_A_CTRL, 32'h0);
        peer(5'h1E, 8'h33, 11'h040);
        rec(5'h1E, 8'h33);
        chk("report_out_valid", 32'(rov), 32'h0);
        peer(5'h10, 8'h33, 11'h001);
        rec(5'h1F, 8'h5A);
        chk("report_out_valid", 32'(rov), 32'h1);
        rd_reg(`ERC_A_REC, 32'h0000_331E);
        wr_reg(`ERC_A_CTRL, 32'h2);
        pulse(11'h040);
        rec(5'h1A, 8'h5A);
        wr_reg(`ERC_A_CTRL, 32'h4);
        @(posedge clock);
        sc_in <= 1'b1;
        @(posedge clock);
        sc_in <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rec(5'h15, 8'h5A);
        wr_reg(`ERC_A_CTRL, 32'h1);
        wr_reg(`ERC_A_CMD, 32'h13);
        rd_reg(`ERC_A_LOG, 32'h0000_A513);
        rd_reg(`ERC_A_STAT, 32'h3);
        wr_reg(`ERC_A_CTRL, 32'h1);
        wr_reg(`ERC_A_CMD, 32'h11);
        rd_reg(`ERC_A_STAT, 32'h1);
        rd_reg(8'h40, 32'h0);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        #1;
        rec(5'h00, 8'h00);
        chk("status_change_out", 32'(scout), 32'h0);
        chk("report_out_type", 32'(rot), 32'h0);
        rd_reg(`ERC_A_LOG, 32'h0);
        test_done();
    end
endmodule

`default_nettype wire
